// >>> hw/cfac_pkg.sv
package cfac_pkg;

  typedef enum logic [1:0] {
    OP_STATUS  = 2'h0,
    OP_RD_BIN  = 2'h1,
    OP_UPD_BIN = 2'h2,
    OP_RD_REC  = 2'h3
  } cfac_op_t;

  typedef struct packed {
    cfac_op_t   op;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] len;
  } cfac_cmd_t;

  typedef enum logic [2:0] {
    RES_OK     = 3'h0,
    RES_PARAM  = 3'h1,
    RES_ACCESS = 3'h2,
    RES_NOFILE = 3'h3,
    RES_RANGE  = 3'h4,
    RES_NODATA = 3'h5
  } cfac_res_t;

  typedef enum logic [1:0] {
    SEL_SELECT = 2'h0,
    SEL_NAME   = 2'h1,
    SEL_NONE   = 2'h2
  } cfac_sel_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_READ  = 4'h2,
    S_WRITE = 4'h4,
    S_DONE  = 4'h8
  } cfac_state_t;

  localparam logic [7:0] APP_NONE    = 8'h00;
  localparam logic [7:0] APP_INIT    = 8'h01;
  localparam logic [7:0] APP_TERM    = 8'h02;
  localparam logic [7:0] STS_SELECT  = 8'h00;
  localparam logic [7:0] STS_NAME    = 8'h01;
  localparam logic [7:0] STS_NODATA  = 8'h0C;
  localparam logic [2:0] SFI_BIN_TAG = 3'h4;
  localparam logic [4:0] SFI_CUR     = 5'h00;
  localparam logic [4:0] SFI_RFU     = 5'h1F;
  localparam logic [2:0] MODE_NEXT   = 3'h2;
  localparam logic [2:0] MODE_PREV   = 3'h3;
  localparam logic [1:0] MODE_ABS    = 2'h2;
  localparam logic [7:0] REC_CURRENT = 8'h00;
  localparam logic [1:0] RST_APP     = 2'h0;

endpackage : cfac_pkg

// >>> hw/cfac_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Status first parameter: 0 none, 1 application initialized, 2 termination.
// - Status second parameter: 0 select reply, 1 name, 0x0C nothing.
// - Status accepts expected length absent, zero, or a maximum.
// - Binary read only on current transparent file with read access.
// - P1 b8 clear: P1 b7..b1 high offset, P2 low offset.
// - P1 top bits 100: b5..b1 short file id, P2 is offset.
// - Binary read returns exactly expected-length bytes; no command data.
// - Binary update needs update access; overwrites bytes at offset.
// - Binary update decodes parameters as read; command length sizes data.
// - Record read on linear or cyclic file with read access; whole record.
// - Failed record read leaves record pointer unchanged.
// - Current and absolute modes read without moving pointer.
// - Next increments pointer first; unset pointer goes to first record.
// - Next on linear file at last record: pointer kept, no data.
// - Next on cyclic file at last record wraps to first.
// - Previous decrements pointer first; unset pointer goes to last record.
// - Previous on linear file at first record: pointer kept, no data.
// - Previous on cyclic file at first record wraps to last.
// - Record P2 b8..b4 zero is current file, else short file id.
// - Modes 010 next, 011 previous, 10x absolute; record zero current.

module cfac_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  output logic      [W-1:0] outData,
  output logic              outValid,
  input  wire logic         outReady
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;
  assign outData = mem[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= inData;
    end
  end

  // Flags kept as flops so both handshakes leave straight from registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      inReady  <= 1'b1;
      outValid <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      inReady  <= cnt_d != (AW+1)'(D);
      outValid <= cnt_d != '0;
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
    end
  end

endmodule : cfac_fifo

module cfac_top #(
  parameter int TF_BYTES   = 256,
  parameter int REC_NUM    = 8,
  parameter int REC_LEN    = 16,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire cfac_pkg::cfac_cmd_t cmd,
  input  wire logic               cmdValid,
  output logic                    cmdReady,
  input  wire logic               fileSelected,
  input  wire logic               curIsTransparent,
  input  wire logic               curIsCyclic,
  input  wire logic [4:0]         curSfi,
  input  wire logic               readAllowed,
  input  wire logic               updateAllowed,
  input  wire logic [7:0]         wrData,
  input  wire logic               wrValid,
  output logic                    wrReady,
  output logic [7:0]              rspData,
  output logic                    rspValid,
  input  wire logic               rspReady,
  output logic                    doneValid,
  output cfac_pkg::cfac_res_t     doneCode,
  output logic [1:0]              appIndication,
  output cfac_pkg::cfac_sel_t     statusSel,
  output logic [7:0]              recPointer,
  input  wire logic               provWrite,
  input  wire logic [15:0]        provAddr,
  input  wire logic [7:0]         provData
);
  localparam int TA = $clog2(TF_BYTES);
  localparam int RA = $clog2(REC_NUM * REC_LEN);
  localparam int RW = $clog2(REC_NUM);
  localparam logic [RW-1:0] LAST = RW'(REC_NUM - 1);

  logic [7:0] tMem   [TF_BYTES];
  logic [7:0] recMem [REC_NUM * REC_LEN];

  cfac_pkg::cfac_state_t state_q;
  cfac_pkg::cfac_res_t   res_q;
  cfac_pkg::cfac_res_t   res;
  logic          cmdReady_q;
  logic          wrReady_q;
  logic [15:0]   addr_q;
  logic [8:0]    left_q;
  logic          srcRec_q;
  logic [RW-1:0] recPtr_q;
  logic          ptrSet_q;
  logic          accept;
  logic          pushFire;
  logic          wrFire;
  logic          fifoReady;
  logic [7:0]    rdByte;
  logic          gRead;
  logic          gWrite;
  logic          isRec;
  logic [15:0]   nAddr;
  logic [8:0]    nLen;
  logic [RW-1:0] nPtr;
  logic [15:0]   off;
  logic [4:0]    short_file_id;

  function automatic logic [15:0] recBase(input logic [RW-1:0] idx);
    recBase = 16'(idx * REC_LEN);
  endfunction : recBase

  function automatic logic [8:0] leBytes(input logic [7:0] le);
    leBytes = (le == 8'h00) ? 9'h100 : {1'b0, le};
  endfunction : leBytes

  assign accept   = cmdValid && cmdReady_q;
  assign pushFire = (state_q == cfac_pkg::S_READ) && fifoReady;
  assign wrFire   = wrValid && wrReady_q;
  assign rdByte   = srcRec_q ? recMem[addr_q[RA-1:0]] : tMem[addr_q[TA-1:0]];
  assign cmdReady = cmdReady_q;
  assign wrReady  = wrReady_q;

  always_comb begin
    res    = cfac_pkg::RES_OK;
    gRead  = 1'b0;
    gWrite = 1'b0;
    isRec  = 1'b0;
    nAddr  = 16'h0000;
    nLen   = 9'h000;
    nPtr   = recPtr_q;
    off    = 16'h0000;
    short_file_id    = cmd.p2[7:3];
    unique case (cmd.op)
      cfac_pkg::OP_STATUS: begin
        // Any expected length is taken as is
        if (cmd.p1 > cfac_pkg::APP_TERM) begin
          res = cfac_pkg::RES_PARAM;
        end else if (cmd.p2 != cfac_pkg::STS_SELECT &&
                     cmd.p2 != cfac_pkg::STS_NAME &&
                     cmd.p2 != cfac_pkg::STS_NODATA) begin
          res = cfac_pkg::RES_PARAM;
        end
      end
      cfac_pkg::OP_RD_BIN, cfac_pkg::OP_UPD_BIN: begin
        nLen = (cmd.op == cfac_pkg::OP_RD_BIN) ? leBytes(cmd.len)
                                               : {1'b0, cmd.len};
        if (!cmd.p1[7]) begin
          off = {1'b0, cmd.p1[6:0], cmd.p2};
        end else if (cmd.p1[7:5] == cfac_pkg::SFI_BIN_TAG) begin
          off = {8'h00, cmd.p2};
        end
        if ((cmd.p1[7] && cmd.p1[7:5] != cfac_pkg::SFI_BIN_TAG) ||
            nLen == 9'h000) begin
          res = cfac_pkg::RES_PARAM;
        end else if (!curIsTransparent ||
                     (cmd.p1[7] && cmd.p1[4:0] != curSfi)) begin
          res = cfac_pkg::RES_NOFILE;
        end else if (cmd.op == cfac_pkg::OP_RD_BIN ? !readAllowed
                                                    : !updateAllowed) begin
          res = cfac_pkg::RES_ACCESS;
        end else if ({1'b0, off} + {8'h00, nLen} > 17'(TF_BYTES)) begin
          res = cfac_pkg::RES_RANGE;
        end
        nAddr  = off;
        gRead  = res == cfac_pkg::RES_OK && cmd.op == cfac_pkg::OP_RD_BIN;
        gWrite = res == cfac_pkg::RES_OK && cmd.op == cfac_pkg::OP_UPD_BIN;
      end
      cfac_pkg::OP_RD_REC: begin
        isRec = 1'b1;
        nLen  = 9'(REC_LEN);
        if (short_file_id == cfac_pkg::SFI_RFU ||
            (cmd.p2[2:0] != cfac_pkg::MODE_NEXT &&
             cmd.p2[2:0] != cfac_pkg::MODE_PREV &&
             cmd.p2[2:1] != cfac_pkg::MODE_ABS)) begin
          res = cfac_pkg::RES_PARAM;
        end else if (curIsTransparent ||
                     (short_file_id != cfac_pkg::SFI_CUR && short_file_id != curSfi)) begin
          res = cfac_pkg::RES_NOFILE;
        end else if (!readAllowed) begin
          res = cfac_pkg::RES_ACCESS;
        end else if (cmd.p2[2:0] == cfac_pkg::MODE_NEXT) begin
          // Record number byte is ignored here
          if (!ptrSet_q) begin
            nPtr = '0;
          end else if (recPtr_q != LAST) begin
            nPtr = recPtr_q + 1'b1;
          end else if (curIsCyclic) begin
            nPtr = '0;
          end else begin
            res = cfac_pkg::RES_NODATA;
          end
        end else if (cmd.p2[2:0] == cfac_pkg::MODE_PREV) begin
          if (!ptrSet_q) begin
            nPtr = LAST;
          end else if (recPtr_q != '0) begin
            nPtr = recPtr_q - 1'b1;
          end else if (curIsCyclic) begin
            nPtr = LAST;
          end else begin
            res = cfac_pkg::RES_NODATA;
          end
        end else if (cmd.p1 == cfac_pkg::REC_CURRENT) begin
          if (!ptrSet_q) begin
            res = cfac_pkg::RES_RANGE;
          end
        end else if (int'(cmd.p1) > REC_NUM) begin
          res = cfac_pkg::RES_RANGE;
        end
        if (cmd.p2[2:1] == cfac_pkg::MODE_ABS &&
            cmd.p1 != cfac_pkg::REC_CURRENT) begin
          nAddr = recBase(RW'(cmd.p1 - 8'h01));
        end else begin
          nAddr = recBase(nPtr);
        end
        gRead = res == cfac_pkg::RES_OK;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= cfac_pkg::S_IDLE;
      cmdReady_q <= 1'b1;
      wrReady_q  <= 1'b0;
      res_q      <= cfac_pkg::RES_OK;
      doneValid  <= 1'b0;
      doneCode   <= cfac_pkg::RES_OK;
    end else begin
      doneValid <= 1'b0;
      unique case (state_q)
        cfac_pkg::S_IDLE: begin
          if (accept) begin
            cmdReady_q <= 1'b0;
            res_q      <= res;
            if (gRead) begin
              state_q <= cfac_pkg::S_READ;
            end else if (gWrite) begin
              state_q   <= cfac_pkg::S_WRITE;
              wrReady_q <= 1'b1;
            end else begin
              state_q <= cfac_pkg::S_DONE;
            end
          end
        end
        cfac_pkg::S_READ: begin
          if (pushFire && left_q == 9'h001) begin
            state_q <= cfac_pkg::S_DONE;
          end
        end
        cfac_pkg::S_WRITE: begin
          if (wrFire && left_q == 9'h001) begin
            wrReady_q <= 1'b0;
            state_q   <= cfac_pkg::S_DONE;
          end
        end
        cfac_pkg::S_DONE: begin
          doneValid  <= 1'b1;
          doneCode   <= res_q;
          cmdReady_q <= 1'b1;
          state_q    <= cfac_pkg::S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_q   <= 16'h0000;
      left_q   <= 9'h000;
      srcRec_q <= 1'b0;
    end else if (accept) begin
      addr_q   <= nAddr;
      left_q   <= nLen;
      srcRec_q <= isRec;
    end else if (pushFire || wrFire) begin
      addr_q <= addr_q + 16'h0001;
      left_q <= left_q - 9'h001;
    end
  end

  // Pointer moves on a read that will succeed and is cleared to unset on file selection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      recPtr_q   <= '0;
      ptrSet_q   <= 1'b0;
      recPointer <= 8'h01;
    end else if (fileSelected) begin
      recPtr_q   <= '0;
      ptrSet_q   <= 1'b0;
      recPointer <= 8'h01;
    end else if (accept && cmd.op == cfac_pkg::OP_RD_REC &&
                 res == cfac_pkg::RES_OK) begin
      recPtr_q   <= nPtr;
      ptrSet_q   <= ptrSet_q || cmd.p2[1];
      recPointer <= 8'(nPtr) + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      appIndication <= cfac_pkg::RST_APP;
      statusSel     <= cfac_pkg::SEL_SELECT;
    end else if (accept && cmd.op == cfac_pkg::OP_STATUS &&
                 res == cfac_pkg::RES_OK) begin
      appIndication <= cmd.p1[1:0];
      statusSel     <= (cmd.p2 == cfac_pkg::STS_NODATA) ? cfac_pkg::SEL_NONE
                     : cfac_pkg::cfac_sel_t'(cmd.p2[1:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (wrFire) begin
      tMem[addr_q[TA-1:0]] <= wrData;
    end
  end

  // Record contents are loaded by the file system, not by this block
  always_ff @(posedge clk) begin
    if (provWrite) begin
      recMem[provAddr[RA-1:0]] <= provData;
    end
  end

  cfac_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inData   (rdByte),
    .inValid  (state_q == cfac_pkg::S_READ),
    .inReady  (fifoReady),
    .outData  (rspData),
    .outValid (rspValid),
    .outReady (rspReady)
  );

  logic [8:0] pushCnt_q;
  logic [8:0] reqLen_q;

  // Length asked for, kept to check the pushed count at the end
  always_ff @(posedge clk) begin
    if (accept) begin
      reqLen_q <= nLen;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || accept) begin
      pushCnt_q <= 9'h000;
    end else if (pushFire) begin
      pushCnt_q <= pushCnt_q + 9'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  status_ind_a: assert property (accept && cmd.op == cfac_pkg::OP_STATUS &&
    cmd.p1 <= cfac_pkg::APP_TERM && res == cfac_pkg::RES_OK
    |=> appIndication == $past(cmd.p1[1:0]))
    else $error("application indication not taken");
  status_rfu_a: assert property (accept && cmd.op == cfac_pkg::OP_STATUS &&
    cmd.p2 == 8'h02 |-> ##2 doneValid && doneCode == cfac_pkg::RES_PARAM)
    else $error("reserved status selector accepted");
  bin_noread_a: assert property (accept && cmd.op == cfac_pkg::OP_RD_BIN &&
    !readAllowed |=> state_q == cfac_pkg::S_DONE)
    else $error("binary read without access");
  bin_offset_a: assert property (accept && gRead && !cmd.p1[7] &&
    cmd.op == cfac_pkg::OP_RD_BIN |=> addr_q == $past({1'b0, cmd.p1[6:0],
    cmd.p2}))
    else $error("binary offset wrong");
  bin_sfi_a: assert property (accept && cmd.op == cfac_pkg::OP_RD_BIN &&
    cmd.p1[7:5] == 3'h4 && cmd.p1[4:0] != curSfi && curIsTransparent
    |-> ##2 doneCode == cfac_pkg::RES_NOFILE)
    else $error("short file id mismatch missed");
  bin_count_a: assert property (doneValid && doneCode == cfac_pkg::RES_OK &&
    $past(state_q, 2) == cfac_pkg::S_READ |-> pushCnt_q == reqLen_q)
    else $error("read byte count differs from request");
  upd_write_a: assert property (wrFire
    |=> tMem[$past(addr_q[TA-1:0])] == $past(wrData))
    else $error("update byte not stored");
  rec_hold_a: assert property (accept && cmd.op == cfac_pkg::OP_RD_REC &&
    res != cfac_pkg::RES_OK && !fileSelected |=> $stable(recPtr_q))
    else $error("pointer moved on failed read");
  rec_next_a: assert property (accept && gRead && isRec && !ptrSet_q &&
    cmd.p2[2:0] == 3'h2 && !fileSelected |=> recPtr_q == '0 && ptrSet_q)
    else $error("next from unset pointer wrong");
  lin_end_a: assert property (accept && isRec && ptrSet_q &&
    recPtr_q == LAST && !curIsCyclic && cmd.p2[2:0] == 3'h2 &&
    res != cfac_pkg::RES_PARAM && res != cfac_pkg::RES_NOFILE &&
    readAllowed |-> ##2 doneCode == cfac_pkg::RES_NODATA)
    else $error("linear next past end");
  cyc_wrap_a: assert property (accept && gRead && isRec && ptrSet_q &&
    recPtr_q == '0 && curIsCyclic && cmd.p2[2:0] == 3'h3 &&
    !fileSelected |=> recPtr_q == LAST)
    else $error("cyclic previous did not wrap");

endmodule : cfac_top

// >>> test/cfac_term.sv
`timescale 1ns/1ns
module cfac_term (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic [7:0] rspData,
  input  wire logic       rspValid,
  output logic            rspReady,
  input  wire logic       wrReady,
  output logic      [7:0] wrData,
  output logic            wrValid
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];

  initial begin
    rspReady = 1'b1;
    wrValid  = 1'b0;
    wrData   = 8'hA5;
  end

  // Slow mode takes a byte every other cycle so the response FIFO backs up
  always @(posedge clk) begin
    if (rspValid && rspReady) rxq.push_back(rspData);
    rspReady <= stall ? ~rspReady : 1'b1;
  end

  // A byte stands until taken; an idle line inverts the data byte every cycle
  always @(posedge clk) begin
    if (wrValid && wrReady) void'(txq.pop_front());
    if (txq.size() > 0) begin
      wrValid <= 1'b1;
      wrData  <= txq[0];
    end else begin
      wrValid <= 1'b0;
      wrData  <= ~wrData;
    end
  end
endmodule : cfac_term

// >>> test/cfac_top_tb.sv
`timescale 1ns/1ns
module cfac_top_tb;
  localparam int RN = 4;
  localparam int RL = 4;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  cfac_pkg::cfac_cmd_t cmd = '0;
  logic                cmdValid = 1'b0;
  logic                fileSel = 1'b0;
  logic                isTr = 1'b1;
  logic                isCyc = 1'b0;
  logic                rdOk = 1'b1;
  logic                upOk = 1'b1;
  logic                stall = 1'b0;
  logic                provWrite = 1'b0;
  logic [15:0]         provAddr = '0;
  logic [7:0]          provData = '0;
  logic [4:0]          curSfi = 5'h05;
  logic                cmdReady, wrReady, wrValid, rspValid, rspReady;
  logic                doneValid;
  logic [7:0]          wrData, rspData, recPointer;
  logic [1:0]          appInd;
  cfac_pkg::cfac_res_t doneCode;
  cfac_pkg::cfac_sel_t statusSel;
  int                  failCount = 0;
  int                  nCompared = 0;
  logic [7:0]          stsP2[3] = '{8'h00, 8'h01, 8'h0C};
  cfac_pkg::cfac_sel_t stsSel[3] = '{cfac_pkg::SEL_SELECT,
                                     cfac_pkg::SEL_NAME, cfac_pkg::SEL_NONE};
  logic [7:0]          errP1[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05};
  logic [7:0]          errP2[6] = '{8'h01, 8'h06, 8'hFA, 8'h32, 8'h02, 8'h04};
  cfac_pkg::cfac_res_t errC[6] = '{cfac_pkg::RES_PARAM, cfac_pkg::RES_PARAM,
    cfac_pkg::RES_PARAM, cfac_pkg::RES_NOFILE, cfac_pkg::RES_ACCESS,
    cfac_pkg::RES_RANGE};

  cfac_top #(.TF_BYTES(512), .REC_NUM(RN), .REC_LEN(RL), .FIFO_DEPTH(8))
  i_cfac_top (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .fileSelected(fileSel), .curIsTransparent(isTr),
    .curIsCyclic(isCyc), .curSfi(curSfi), .readAllowed(rdOk),
    .updateAllowed(upOk), .wrData(wrData), .wrValid(wrValid),
    .wrReady(wrReady), .rspData(rspData), .rspValid(rspValid),
    .rspReady(rspReady), .doneValid(doneValid), .doneCode(doneCode),
    .appIndication(appInd), .statusSel(statusSel), .recPointer(recPointer),
    .provWrite(provWrite), .provAddr(provAddr), .provData(provData)
  );

  cfac_term i_cfac_term (
    .clk(clk), .stall(stall), .rspData(rspData), .rspValid(rspValid),
    .rspReady(rspReady), .wrReady(wrReady), .wrData(wrData),
    .wrValid(wrValid)
  );

  always #25 clk = ~clk;

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 7 + 3);
  endfunction : pat

  function automatic logic [7:0] recB(input int r, input int b);
    return 8'(r * 16 + b);
  endfunction : recB

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic completeRun();
    $display("Compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : completeRun

  // Request held from one edge until the edge that sees cmdReady high
  task automatic run(input cfac_pkg::cfac_op_t op, input logic [7:0] p1,
                     input logic [7:0] p2, input logic [7:0] ln,
                     input cfac_pkg::cfac_res_t code, input int nb);
    int k;
    i_cfac_term.rxq.delete();
    @(posedge clk);
    cmd <= '{op: op, p1: p1, p2: p2, len: ln};
    cmdValid <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (cmdReady !== 1'b1 && k < 20);
    if (cmdReady !== 1'b1) failCount++;
    cmdValid <= 1'b0;
    k = 0;
    do begin @(posedge clk); k++; end while (doneValid !== 1'b1 && k < 3000);
    if (doneValid !== 1'b1) failCount++;
    chk(16'(doneCode), 16'(code));
    k = 0;
    while (i_cfac_term.rxq.size() < nb && k < 700) begin
      @(posedge clk);
      k++;
    end
    repeat (3) @(posedge clk);
    chk(16'(i_cfac_term.rxq.size()), 16'(nb));
  endtask : run

  task automatic upd(input logic [7:0] p1, input logic [7:0] p2,
                     input int n, input int base);
    for (int i = 0; i < n; i++) i_cfac_term.txq.push_back(pat(base + i));
    run(cfac_pkg::OP_UPD_BIN, p1, p2, 8'(n), cfac_pkg::RES_OK, 0);
  endtask : upd

  task automatic rb(input logic [7:0] p1, input logic [7:0] p2,
                    input int n, input int base);
    run(cfac_pkg::OP_RD_BIN, p1, p2, 8'(n), cfac_pkg::RES_OK, n);
    for (int i = 0; i < n; i++)
      chk(16'(i_cfac_term.rxq[i]), 16'(pat(base + i)));
  endtask : rb

  // Le deliberately nonzero: a whole record comes back regardless
  task automatic rr(input logic [7:0] p1, input logic [7:0] p2,
                    input cfac_pkg::cfac_res_t c, input int r, input int p);
    run(cfac_pkg::OP_RD_REC, p1, p2, 8'h02, c,
        (c == cfac_pkg::RES_OK) ? RL : 0);
    for (int b = 0; b < RL && c == cfac_pkg::RES_OK; b++)
      chk(16'(i_cfac_term.rxq[b]), 16'(recB(r, b)));
    chk(16'(recPointer), 16'(p));
  endtask : rr

  task automatic sel();
    @(posedge clk);
    fileSel <= 1'b1;
    @(posedge clk);
    fileSel <= 1'b0;
  endtask : sel

  initial begin
    #(20000 * 50);
    failCount++;
    completeRun();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'({cmdReady, wrReady, rspValid, doneValid, doneCode, appInd,
             statusSel}), 16'h0400);
    chk(16'(recPointer), 16'h0001);
    for (int r = 1; r <= RN; r++)
      for (int b = 0; b < RL; b++) begin
        @(posedge clk);
        provWrite <= 1'b1;
        provAddr  <= 16'((r - 1) * RL + b);
        provData  <= recB(r, b);
      end
    @(posedge clk);
    provWrite <= 1'b0;
    for (int i = 0; i < 3; i++)
      for (int j = 0; j < 3; j++) begin
        run(cfac_pkg::OP_STATUS, 8'(i), stsP2[j], 8'(j * 127),
            cfac_pkg::RES_OK, 0);
        chk(16'(appInd), 16'(i));
        chk(16'(statusSel), 16'(stsSel[j]));
      end
    run(cfac_pkg::OP_STATUS, 8'h01, 8'h02, 8'h00,
        cfac_pkg::RES_PARAM, 0);
    chk(16'(statusSel), 16'(cfac_pkg::SEL_NONE));
    run(cfac_pkg::OP_STATUS, 8'h03, 8'h00, 8'h00,
        cfac_pkg::RES_PARAM, 0);
    chk(16'(appInd), 16'h0002);
    upd(8'h01, 8'hF0, 10, 0);
    stall <= 1'b1;
    rb(8'h01, 8'hF0, 10, 0);
    stall <= 1'b0;
    run(cfac_pkg::OP_RD_BIN, 8'h01, 8'hFF, 8'h02,
        cfac_pkg::RES_RANGE, 0);
    run(cfac_pkg::OP_UPD_BIN, 8'h00, 8'h20, 8'h00,
        cfac_pkg::RES_PARAM, 0);
    upd(8'h85, 8'h20, 3, 20);
    rb(8'h00, 8'h20, 3, 20);
    run(cfac_pkg::OP_RD_BIN, 8'h86, 8'h20, 8'h01,
        cfac_pkg::RES_NOFILE, 0);
    rdOk <= 1'b0;
    run(cfac_pkg::OP_RD_BIN, 8'h00, 8'h20, 8'h01,
        cfac_pkg::RES_ACCESS, 0);
    rdOk <= 1'b1;
    upOk <= 1'b0;
    run(cfac_pkg::OP_UPD_BIN, 8'h00, 8'h20, 8'h01,
        cfac_pkg::RES_ACCESS, 0);
    upOk <= 1'b1;
    rb(8'h00, 8'h20, 1, 20);
    run(cfac_pkg::OP_RD_BIN, 8'h00, 8'h00, 8'h00,
        cfac_pkg::RES_OK, 256);
    isTr <= 1'b0;
    sel();
    for (int r = 1; r <= RN; r++)
      rr(8'h00, 8'h02, cfac_pkg::RES_OK, r, r);
    rr(8'h00, 8'h02, cfac_pkg::RES_NODATA, 0, RN);
    rr(8'h00, 8'h04, cfac_pkg::RES_OK, RN, RN);
    rr(8'h02, 8'h04, cfac_pkg::RES_OK, 2, RN);
    for (int i = 0; i < 6; i++) begin
      rdOk <= (i != 4);
      rr(errP1[i], errP2[i], errC[i], 0, RN);
    end
    rdOk <= 1'b1;
    rr(8'h03, 8'h05, cfac_pkg::RES_OK, 3, RN);
    rr(8'h00, 8'h2B, cfac_pkg::RES_OK, 3, 3);
    rr(8'h00, 8'h03, cfac_pkg::RES_OK, 2, 2);
    rr(8'h00, 8'h03, cfac_pkg::RES_OK, 1, 1);
    rr(8'h00, 8'h03, cfac_pkg::RES_NODATA, 0, 1);
    sel();
    rr(8'h00, 8'h04, cfac_pkg::RES_RANGE, 0, 1);
    rr(8'h00, 8'h03, cfac_pkg::RES_OK, RN, RN);
    isCyc <= 1'b1;
    sel();
    rr(8'h00, 8'h02, cfac_pkg::RES_OK, 1, 1);
    rr(8'h00, 8'h03, cfac_pkg::RES_OK, RN, RN);
    rr(8'h00, 8'h02, cfac_pkg::RES_OK, 1, 1);
    completeRun();
  end
endmodule : cfac_top_tb
